// [rtl/phy_basic_mode_control.sv]
// basic mode control register bank of the phy with its apb slave
// Contract
// [R1] self clearing bits drop once event ends
// [R2] clear on read field ignores writes, read zeroes
// [R3] latched low holds zero until read
// [R4] latched high holds one until read
// [R5] strap defaults sampled at reset; fixed bits constant
// [R6] reset bit runs reset, self clears, relatches straps
// [R7] loopback returns mac transmit data to receive
// [R8] loopback start gives receive dead period
// [R9] forced speed from bits six and thirteen
// [R10] autoneg enable strapped, overrides forced speed duplex
// [R11] power down leaves only registers alive
// [R12] power down is field or pin
// [R13] isolate cuts mac data, keeps management
// [R14] restart only when enabled, clears once begun
// [R15] writing zero to restart changes nothing
// [R16] forced duplex bit, strapped reset value
// [R17] collision test echoes transmit enable on col
// [R18] reserved low six bits read zero
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "basic_mode_consts.svh"
module phy_basic_mode_control
	import basic_mode_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int DATA_W = 8,
	parameter int DEAD_W = 17,
	parameter logic [DEAD_W-1:0] LOOP_DEAD_CYCLES = DEAD_W'(`LOOP_DEAD_CYCLES),
	parameter logic [7:0] SOFT_RESET_CYCLES = 8'(`SOFT_RESET_CYCLES)
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic strapAnEnable,
	input wire logic strapFullDuplex,
	input wire logic powerDownInputPin_b,
	input wire logic linkUp,
	input wire logic remoteFault,
	input wire logic [1:0] anSpeed,
	input wire logic anFullDuplex,
	input wire logic anBegun,
	input wire logic txEn,
	input wire logic [DATA_W-1:0] txd,
	input wire logic lineRxDv,
	input wire logic [DATA_W-1:0] lineRxd,
	output logic macRxDv,
	output logic [DATA_W-1:0] macRxd,
	output logic lineTxEn,
	output logic [DATA_W-1:0] lineTxd,
	output logic col,
	output logic phyPowerDown,
	output logic portIsolated,
	output logic loopbackOn,
	output logic [1:0] speedSel,
	output logic fullDuplex,
	output logic autoNegEnabled,
	output logic autoNegRestart,
	output logic coreReset
);
	reset_state_type rstState_q; // software reset sequence
	reset_state_type rstState_d;
	logic [1:0] forcedSpeed_q; // {speed msb, speed lsb}
	logic powerDown_q; // stored power down field
	logic fullDuplexField; // stored duplex field
	logic colTest_q; // collision test enable
	logic loopPrev_q; // loopback one cycle ago, for start detect
	logic colPrev_q; // col one cycle ago, for the counter
	logic [7:0] colCount_q; // clear on read count of col assertions
	logic accept; // apb access phase, first cycle
	logic hitCtrl;
	logic hitEvt;
	logic wrCtrl; // write to control taken this cycle
	logic wrReset; // write sets the reset bit
	logic rdEvt; // read of event register taken this cycle
	logic rstBit; // reset bit as software sees it
	logic resetDone;
	logic pdEff; // field or pin
	logic deadStart;
	logic deadBusy;
	logic deadActive; // receive must stay quiet
	logic linkFlag;
	logic faultFlag;
	logic colRise;
	logic [15:0] ctrlStored; // fields without live views
	logic [15:0] ctrlView; // what a read returns
	logic [15:0] wrData; // byte-merged write value
	logic [15:0] evtView;
	logic [31:0] readMux;

	// decode; one wait state lets read data come from a flop
	assign accept = psel & penable & ~pready;
	assign hitCtrl = (paddr == ADDR_W'(`CTRL_OFFSET));
	assign hitEvt = (paddr == ADDR_W'(`EVENT_OFFSET));
	// writes during a software reset are dropped
	assign wrCtrl = accept & pwrite & hitCtrl & (rstState_q == RST_IDLE);
	assign wrReset = wrCtrl & wrData[`RESET_BIT]; // [R6]
	// event register has no writable bits at all
	assign rdEvt = accept & ~pwrite & hitEvt; // [R2]
	assign rstBit = (rstState_q != RST_IDLE); // [R1] [R6]
	assign pdEff = powerDown_q | ~powerDownInputPin_b; // [R12]
	assign deadStart = loopbackOn & ~loopPrev_q; // [R8]
	assign deadActive = deadStart | deadBusy; // [R8]
	assign colRise = col & ~colPrev_q;

	// stored fields; reset and restart read back as zero here so that a
	// partial byte write cannot fire them again
	always_comb begin
		ctrlStored = 16'h0000; // reserved bits stay zero [R18]
		ctrlStored[`LOOPBACK_BIT] = loopbackOn;
		ctrlStored[`SPEED_LSB_BIT] = forcedSpeed_q[0];
		ctrlStored[`AN_ENABLE_BIT] = autoNegEnabled;
		ctrlStored[`POWER_DOWN_BIT] = powerDown_q;
		ctrlStored[`ISOLATE_BIT] = portIsolated;
		ctrlStored[`DUPLEX_BIT] = fullDuplexField;
		ctrlStored[`COL_TEST_BIT] = colTest_q;
		ctrlStored[`SPEED_MSB_BIT] = forcedSpeed_q[1];
	end

	// read view adds the live reset, restart and pin-merged power down
	always_comb begin
		ctrlView = ctrlStored;
		ctrlView[`RESET_BIT] = rstBit; // [R6]
		ctrlView[`RESTART_BIT] = autoNegRestart; // [R14]
		ctrlView[`POWER_DOWN_BIT] = pdEff; // [R12]
	end

	// byte lanes: only strobed bytes of the low half change
	assign wrData = {pstrb[1] ? pwdata[15:8] : ctrlStored[15:8],
		pstrb[0] ? pwdata[7:0] : ctrlStored[7:0]};

	// event register: link latched low, fault latched high, fixed ability
	always_comb begin
		evtView = 16'h0000;
		evtView[`LINK_BIT] = linkFlag; // [R3]
		evtView[`FAULT_BIT] = faultFlag; // [R4]
		evtView[`ABILITY_BIT] = `ABILITY_VALUE; // [R5]
		evtView[`COUNT_MSB:`COUNT_LSB] = colCount_q; // [R2]
	end

	// read mux; upper half and unmapped addresses read zero
	always_comb begin
		readMux = 32'h0000_0000;
		if (hitCtrl) begin
			readMux = {16'h0000, ctrlView};
		end else if (hitEvt) begin
			readMux = {16'h0000, evtView};
		end
	end

	// apb answer: pready one cycle after the access phase opens
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'h0;
			pslverr <= 1'h0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= accept;
			pslverr <= accept & ~(hitCtrl | hitEvt);
			if (accept) begin
				prdata <= pwrite ? 32'h0000_0000 : readMux;
			end
		end
	end

	// software reset sequence next state
	always_comb begin
		rstState_d = rstState_q;
		unique case (rstState_q)
			RST_IDLE: begin
				if (wrReset) begin
					rstState_d = RST_RUN; // [R6]
				end
			end
			RST_RUN: begin
				if (resetDone) begin
					rstState_d = RST_RELATCH; // [R1]
				end
			end
			RST_RELATCH: begin
				rstState_d = RST_IDLE;
			end
		endcase
	end

	// hardware reset enters relatch so straps are caught after release
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstState_q <= RST_RELATCH; // [R5]
			coreReset <= 1'h1;
		end else begin
			rstState_q <= rstState_d;
			coreReset <= (rstState_d != RST_IDLE); // [R6]
		end
	end

	// length of the software reset of the phy core
	hold_timer #(
		.WIDTH(8)
	) u_reset_timer (
		.clk(clk),
		.rst_b(rst_b),
		.load(wrReset),
		.loadValue(SOFT_RESET_CYCLES),
		.busy(),
		.done(resetDone)
	);

	// control fields: defaults on reset write, straps on relatch
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loopbackOn <= `FIELD_RESET;
			forcedSpeed_q <= `SPEED_RESET;
			autoNegEnabled <= `FIELD_RESET;
			powerDown_q <= `FIELD_RESET;
			portIsolated <= `FIELD_RESET;
			fullDuplexField <= `FIELD_RESET;
			colTest_q <= `FIELD_RESET;
		end else if (wrReset) begin
			loopbackOn <= `FIELD_RESET; // [R6]
			forcedSpeed_q <= `SPEED_RESET; // [R9]
			autoNegEnabled <= `FIELD_RESET;
			powerDown_q <= `FIELD_RESET;
			portIsolated <= `FIELD_RESET;
			fullDuplexField <= `FIELD_RESET;
			colTest_q <= `FIELD_RESET;
		end else if (rstState_q == RST_RELATCH) begin
			autoNegEnabled <= strapAnEnable; // [R5] [R10]
			fullDuplexField <= strapFullDuplex; // [R16]
		end else if (wrCtrl) begin
			loopbackOn <= wrData[`LOOPBACK_BIT];
			forcedSpeed_q <= {wrData[`SPEED_MSB_BIT], wrData[`SPEED_LSB_BIT]};
			autoNegEnabled <= wrData[`AN_ENABLE_BIT];
			powerDown_q <= wrData[`POWER_DOWN_BIT]; // [R11]
			portIsolated <= wrData[`ISOLATE_BIT]; // [R13]
			fullDuplexField <= wrData[`DUPLEX_BIT];
			colTest_q <= wrData[`COL_TEST_BIT];
		end
	end

	// restart request: set only with negotiation enabled in the same
	// write, cleared by the engine; a written zero is simply ignored
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			autoNegRestart <= 1'h0;
		end else if (wrReset || rstState_q != RST_IDLE) begin
			autoNegRestart <= 1'h0;
		end else begin
			autoNegRestart <= (wrCtrl & wrData[`RESTART_BIT] // [R14]
				& wrData[`AN_ENABLE_BIT]) | (autoNegRestart & ~anBegun); // [R15]
		end
	end

	// speed and duplex to the core; reserved forced code keeps last speed
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			speedSel <= `SPEED_RESET;
			fullDuplex <= `FIELD_RESET;
			phyPowerDown <= 1'h0;
		end else begin
			phyPowerDown <= pdEff; // [R11] [R12]
			if (autoNegEnabled) begin
				speedSel <= anSpeed; // [R10]
				fullDuplex <= anFullDuplex;
			end else begin
				fullDuplex <= fullDuplexField; // [R16]
				if (forcedSpeed_q != SPEED_RSVD) begin
					speedSel <= forcedSpeed_q; // [R9]
				end
			end
		end
	end

	// receive stays quiet while the descrambler would relock
	hold_timer #(
		.WIDTH(DEAD_W)
	) u_dead_timer (
		.clk(clk),
		.rst_b(rst_b),
		.load(deadStart),
		.loadValue(LOOP_DEAD_CYCLES),
		.busy(deadBusy),
		.done()
	);

	// mac data path: isolate and power down win over loopback; in
	// loopback nothing goes to the line
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			macRxDv <= 1'h0;
			macRxd <= '0;
			lineTxEn <= 1'h0;
			lineTxd <= '0;
			loopPrev_q <= 1'h0;
		end else begin
			loopPrev_q <= loopbackOn;
			if (portIsolated || pdEff) begin
				macRxDv <= 1'h0; // [R13] [R11]
				macRxd <= '0;
				lineTxEn <= 1'h0;
				lineTxd <= '0;
			end else if (loopbackOn) begin
				macRxDv <= txEn & ~deadActive; // [R7] [R8]
				macRxd <= deadActive ? '0 : txd;
				lineTxEn <= 1'h0;
				lineTxd <= '0;
			end else begin
				macRxDv <= lineRxDv;
				macRxd <= lineRxd;
				lineTxEn <= txEn;
				lineTxd <= txd;
			end
		end
	end

	// collision test: one cycle is far inside both bit-time limits
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			col <= 1'h0;
			colPrev_q <= 1'h0;
		end else begin
			col <= colTest_q & txEn; // [R17]
			colPrev_q <= col;
		end
	end

	// col counter; a rise in the read cycle restarts it at one
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			colCount_q <= 8'h00;
		end else if (rdEvt) begin
			colCount_q <= {7'h00, colRise}; // [R2]
		end else if (colRise && colCount_q != 8'hFF) begin
			colCount_q <= colCount_q + 8'h01;
		end
	end

	// link latches low on loss, fault latches high
	status_latch #(
		.ACTIVE(1'h0),
		.RESET_VAL(1'h0)
	) u_link_latch (
		.clk(clk),
		.rst_b(rst_b),
		.eventIn(~linkUp),
		.readClr(rdEvt),
		.flag(linkFlag)
	);
	status_latch #(
		.ACTIVE(1'h1),
		.RESET_VAL(1'h0)
	) u_fault_latch (
		.clk(clk),
		.rst_b(rst_b),
		.eventIn(remoteFault),
		.readClr(rdEvt),
		.flag(faultFlag)
	);

	localparam int RstMax = 24; // covers the default reset length

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence resetWrite;
		wrReset;
	endsequence
	sequence resetBusy;
		rstBit[*2];
	endsequence
	a_reset_self_clear: assert property (resetWrite |=> resetBusy ##[1:RstMax] !rstBit) // [R6] [R1]
		else $error("reset bit did not self clear");
	a_cor_clears: assert property (rdEvt && !colRise |=> colCount_q == 8'h00) // [R2]
		else $error("count not cleared by read");
	// a write answers with zero data, so only reads are held to the bit
	a_fixed_bit: assert property (pready && !pslverr && hitEvt && !pwrite // [R5]
		|-> prdata[`ABILITY_BIT])
		else $error("fixed bit read wrong");
	a_strap_relatch: assert property (rstState_q == RST_RELATCH |=> autoNegEnabled == $past(strapAnEnable) && fullDuplexField == $past(strapFullDuplex)) // [R5] [R16]
		else $error("straps not relatched");
	a_loop_route: assert property (loopbackOn && !deadActive && !portIsolated && !pdEff |=> macRxDv == $past(txEn) && macRxd == $past(txd)) // [R7]
		else $error("loopback data not returned");
	a_dead_quiet: assert property ($rose(loopbackOn) |=> !macRxDv[*4]) // [R8]
		else $error("receive valid inside dead time");
	a_forced_speed: assert property (!autoNegEnabled && forcedSpeed_q != SPEED_RSVD |=> speedSel == $past(forcedSpeed_q)) // [R9]
		else $error("forced speed not applied");
	a_an_overrides: assert property (autoNegEnabled |=> speedSel == $past(anSpeed) && fullDuplex == $past(anFullDuplex)) // [R10]
		else $error("forced fields not ignored");
	a_pd_merge: assert property (!powerDownInputPin_b |=> phyPowerDown // [R12] [R11]
		##0 (!hitCtrl || pwrite || !pready || pslverr
		|| prdata[`POWER_DOWN_BIT]))
		else $error("power down pin not merged");
	a_isolate_cut: assert property (portIsolated |=> !macRxDv && !lineTxEn) // [R13]
		else $error("isolated port still passes data");
	a_restart_gate: assert property (wrCtrl && !wrData[`AN_ENABLE_BIT] && !autoNegRestart |=> !autoNegRestart) // [R14]
		else $error("restart taken while disabled");
	a_restart_hold: assert property (autoNegRestart && !anBegun && !wrReset && rstState_q == RST_IDLE |=> autoNegRestart) // [R15]
		else $error("restart dropped without engine start");
	a_col_echo: assert property (colTest_q && txEn |=> col) // [R17]
		else $error("collision test col missing");
	a_col_release: assert property (!txEn |=> !col) // [R17]
		else $error("col held after transmit ended");
	a_rsvd_zero: assert property (pready && hitCtrl && !pslverr |-> prdata[5:0] == 6'h00) // [R18]
		else $error("reserved bits not zero");
endmodule
`default_nettype wire

// [rtl/basic_mode_consts.svh]
// offsets, field positions, reset values and timing counts of the mode block
`ifndef BASIC_MODE_CONSTS_SVH
`define BASIC_MODE_CONSTS_SVH
// byte addresses on the register bus
`define CTRL_OFFSET 12'h000
`define EVENT_OFFSET 12'h004
// control register field positions
`define RESET_BIT 15
`define LOOPBACK_BIT 14
`define SPEED_LSB_BIT 13
`define AN_ENABLE_BIT 12
`define POWER_DOWN_BIT 11
`define ISOLATE_BIT 10
`define RESTART_BIT 9
`define DUPLEX_BIT 8
`define COL_TEST_BIT 7
`define SPEED_MSB_BIT 6
// control register reset values
`define SPEED_RESET 2'h2
`define FIELD_RESET 1'h0
// event register field positions and fixed value
`define LINK_BIT 0
`define FAULT_BIT 1
`define ABILITY_BIT 2
`define COUNT_LSB 8
`define COUNT_MSB 15
`define ABILITY_VALUE 1'h1
// timing
`define CLK_MHZ 250
`define LOOP_DEAD_US 500
`define LOOP_DEAD_CYCLES (`LOOP_DEAD_US * `CLK_MHZ)
`define SOFT_RESET_CYCLES 16
`endif

// [rtl/basic_mode_pkg.sv]
// types shared by the basic mode control block
package basic_mode_pkg;
	// forced speed codes, msb then lsb
	typedef enum logic [1:0] {
		SPEED_10 = 2'h0,
		SPEED_100 = 2'h1,
		SPEED_1000 = 2'h2,
		SPEED_RSVD = 2'h3
	} speed_type;
	// software reset sequence, gray along idle-run-relatch
	typedef enum logic [1:0] {
		RST_IDLE = 2'h0,
		RST_RUN = 2'h1,
		RST_RELATCH = 2'h3
	} reset_state_type;
endpackage

// [rtl/hold_timer.sv]
// down counter that stays busy for a loaded number of cycles
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
	parameter int WIDTH = 17
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [WIDTH-1:0] loadValue,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] count_q; // cycles still to run

	assign busy = (count_q != '0);
	// last cycle of the count; one-cycle pulse
	assign done = (count_q == WIDTH'(1));

	// a fresh load restarts the count even while busy
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= '0;
		end else if (load) begin
			count_q <= loadValue;
		end else if (busy) begin
			count_q <= count_q - WIDTH'(1);
		end
	end

	a_timer_load: assert property (@(posedge clk) disable iff (!rst_b)
		load |=> count_q == $past(loadValue))
		else $error("timer did not take its load value");
	a_timer_step: assert property (@(posedge clk) disable iff (!rst_b)
		!load && busy |=> count_q == $past(count_q) - WIDTH'(1))
		else $error("timer did not count down by one");
endmodule
`default_nettype wire

// [rtl/status_latch.sv]
// status bit that latches on its event and is released by a read
`timescale 1ns/1ps
`default_nettype none
module status_latch #(
	parameter logic ACTIVE = 1'h1,
	parameter logic RESET_VAL = 1'h0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic eventIn,
	input wire logic readClr,
	output logic flag
);
	// the event wins over a read in the same cycle so it is never lost
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag <= RESET_VAL;
		end else if (eventIn) begin
			flag <= ACTIVE;
		end else if (readClr) begin
			flag <= ~ACTIVE;
		end
	end

	a_latch_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R3] [R4]
		flag == ACTIVE && !readClr |=> flag == ACTIVE)
		else $error("latched status let go without a read");
	a_latch_event: assert property (@(posedge clk) disable iff (!rst_b)
		eventIn |=> flag == ACTIVE)
		else $error("latched status missed its event");
endmodule
`default_nettype wire

// [dv/mac_mgmt_model.sv]
// station management side model: apb master issuing one transfer per call
`timescale 1ns/1ps
`default_nettype none
module mac_mgmt_model (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus at time zero; all byte lanes stay enabled
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end
	// setup, access held until pready, then release
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// request stands until the rising edge that sees pready high
		do @(posedge clk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// released lines change so stale values cannot pass for valid
		pwrite <= ~wr;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// [dv/phy_basic_mode_control_tb.sv]
// self-checking bench of the basic mode control register bank
`timescale 1ns/1ps
`default_nettype none
`include "basic_mode_consts.svh"
module phy_basic_mode_control_tb;
	logic clk, rst_b, txEn, lineRxDv, strapAnEnable, strapFullDuplex;
	logic powerDownInputPin_b, linkUp, remoteFault, anFullDuplex, anBegun;
	logic [1:0] anSpeed, speedSel;
	logic [7:0] txd, lineRxd, macRxd, lineTxd, v;
	logic psel, penable, pwrite, pready, pslverr, macRxDv, lineTxEn, col;
	logic phyPowerDown, portIsolated, loopbackOn, fullDuplex;
	logic autoNegEnabled, autoNegRestart, coreReset, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rng, rd, ctrlModel;
	logic [3:0] pstrb;
	int mismatches, check_count, cycles;
	logic [1:0] spd;
	// clock of 4 ns
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// short counts keep the run brief; expectations use these values
	phy_basic_mode_control #(.LOOP_DEAD_CYCLES(17'h10),
		.SOFT_RESET_CYCLES(8'h10)) i_dut (.clk(clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .strapAnEnable(strapAnEnable),
		.strapFullDuplex(strapFullDuplex),
		.powerDownInputPin_b(powerDownInputPin_b), .linkUp(linkUp),
		.remoteFault(remoteFault), .anSpeed(anSpeed),
		.anFullDuplex(anFullDuplex), .anBegun(anBegun), .txEn(txEn),
		.txd(txd), .lineRxDv(lineRxDv), .lineRxd(lineRxd),
		.macRxDv(macRxDv), .macRxd(macRxd), .lineTxEn(lineTxEn),
		.lineTxd(lineTxd), .col(col), .phyPowerDown(phyPowerDown),
		.portIsolated(portIsolated), .loopbackOn(loopbackOn),
		.speedSel(speedSel), .fullDuplex(fullDuplex),
		.autoNegEnabled(autoNegEnabled), .autoNegRestart(autoNegRestart),
		.coreReset(coreReset));
	// management controller on the far side of the register bus
	mac_mgmt_model i_mac (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	// xorshift source for data values
	function automatic logic [31:0] nextRand();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	// one comparison
	task automatic check(input string what, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// write control and mirror it in the model; restart needs bit 12
	task automatic wrCtrl(input logic [31:0] d);
		i_mac.xfer(1'h1, `CTRL_OFFSET, d, rd, err);
		ctrlModel = (d & 32'h7DC0) | ((d[12] & d[9]) ? 32'h0200 :
			(ctrlModel & 32'h0200));
	endtask
	// read and compare data and error response
	task automatic rdChk(input logic [11:0] a, input logic [31:0] e,
		input logic ee);
		i_mac.xfer(1'h0, a, 32'h0, rd, err);
		check("read data", e, rd);
		check("pslverr", {31'h0, ee}, {31'h0, err});
	endtask
	// pin shows in the read value as the power down field
	function automatic logic [31:0] expCtrl();
		return ctrlModel | (powerDownInputPin_b ? 32'h0 : 32'h0800);
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// hang guard, generous against roughly 300 expected cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		rng = 32'h14877E1D;
		{rst_b, txEn, lineRxDv, linkUp, remoteFault, anBegun} = 6'h0;
		{strapAnEnable, strapFullDuplex, powerDownInputPin_b} = 3'h5;
		{anSpeed, anFullDuplex, txd, lineRxd} = 19'h0;
		mismatches = 0;
		check_count = 0;
		cycles = 0;
		tick(6);
		rst_b <= 1'h1;
		tick(3);
		// strap defaults, fixed and reserved bits after reset
		ctrlModel = 32'h1040;
		rdChk(`CTRL_OFFSET, expCtrl(), 1'h0);
		rdChk(`EVENT_OFFSET, 32'h4, 1'h0);
		wrCtrl(32'hFFFF003F);
		rdChk(`CTRL_OFFSET, expCtrl(), 1'h0);
		rdChk(12'h008, 32'h0, 1'h1);
		$display("test reset_values done");
		// every forced speed code, reserved one keeps the last speed
		for (int i = 0; i < 4; i++) begin
			wrCtrl((i[1] << 6) | (i[0] << 13) | (i[0] << 8));
			spd = (i == 3) ? 2'h2 : i[1:0];
			tick(3);
			@(negedge clk);
			check("speedSel", spd, speedSel);
			check("fullDuplex", i[0], fullDuplex);
			rdChk(`CTRL_OFFSET, expCtrl(), 1'h0);
		end
		// negotiated result overrides forced bits
		anSpeed <= 2'(nextRand() % 3);
		anFullDuplex <= 1'h1;
		wrCtrl(32'h1000);
		tick(3);
		@(negedge clk);
		check("an speed", anSpeed, speedSel);
		check("an duplex", 1'h1, fullDuplex);
		check("an enabled", 1'h1, autoNegEnabled);
		// restart holds until begun, clearing write has no effect
		tick(1);
		wrCtrl(32'h1200);
		rdChk(`CTRL_OFFSET, expCtrl(), 1'h0);
		@(negedge clk);
		check("restart", 1'h1, autoNegRestart);
		wrCtrl(32'h1000);
		rdChk(`CTRL_OFFSET, expCtrl(), 1'h0);
		anBegun <= 1'h1;
		tick(1);
		anBegun <= 1'h0;
		ctrlModel &= ~32'h0200;
		tick(2);
		rdChk(`CTRL_OFFSET, expCtrl(), 1'h0);
		wrCtrl(32'h0200);
		rdChk(`CTRL_OFFSET, expCtrl(), 1'h0);
		$display("test speed_autoneg done");
		// normal path, then loopback with its dead period
		v = 8'(nextRand());
		txEn <= 1'h1;
		txd <= v;
		lineRxDv <= 1'h1;
		lineRxd <= ~v;
		tick(3);
		@(negedge clk);
		check("lineTxd", {1'h1, v}, {lineTxEn, lineTxd});
		check("macRxd", {1'h1, ~v}, {macRxDv, macRxd});
		wrCtrl(32'h4000);
		tick(4);
		@(negedge clk);
		check("dead macRxDv", 1'h0, macRxDv);
		tick(20);
		@(negedge clk);
		check("loop macRxd", {1'h1, v}, {macRxDv, macRxd});
		check("loopbackOn", 1'h1, loopbackOn);
		// isolation and power down silence the data paths
		tick(1);
		wrCtrl(32'h0400);
		tick(2);
		@(negedge clk);
		check("isolated", 3'h4, {portIsolated, macRxDv, lineTxEn});
		rdChk(`CTRL_OFFSET, expCtrl(), 1'h0);
		wrCtrl(32'h0800);
		tick(2);
		@(negedge clk);
		check("power down", 2'h2, {phyPowerDown, lineTxEn});
		rdChk(`CTRL_OFFSET, expCtrl(), 1'h0);
		wrCtrl(32'h0000);
		powerDownInputPin_b <= 1'h0;
		tick(2);
		@(negedge clk);
		check("pin power down", 1'h1, phyPowerDown);
		rdChk(`CTRL_OFFSET, expCtrl(), 1'h0);
		powerDownInputPin_b <= 1'h1;
		txEn <= 1'h0;
		$display("test data_paths done");
		// collision test: three transmit bursts give three col rises
		wrCtrl(32'h0080);
		for (int i = 0; i < 3; i++) begin
			txEn <= 1'h1;
			tick(3);
			@(negedge clk);
			check("col on", 1'h1, col);
			tick(1);
			txEn <= 1'h0;
			tick(2);
			@(negedge clk);
			check("col off", 1'h0, col);
			tick(1);
		end
		// clear on read count and both latched status bits
		rdChk(`EVENT_OFFSET, 32'h0304, 1'h0);
		i_mac.xfer(1'h1, `EVENT_OFFSET, 32'hFFFF, rd, err);
		rdChk(`EVENT_OFFSET, 32'h0004, 1'h0);
		linkUp <= 1'h1;
		rdChk(`EVENT_OFFSET, 32'h0004, 1'h0);
		rdChk(`EVENT_OFFSET, 32'h0005, 1'h0);
		linkUp <= 1'h0;
		tick(2);
		linkUp <= 1'h1;
		remoteFault <= 1'h1;
		tick(1);
		remoteFault <= 1'h0;
		rdChk(`EVENT_OFFSET, 32'h0006, 1'h0);
		rdChk(`EVENT_OFFSET, 32'h0005, 1'h0);
		$display("test status_latches done");
		// software reset: bit reads one, writes refused, straps relatched
		{strapAnEnable, strapFullDuplex} <= 2'h1;
		wrCtrl(32'hC000);
		rdChk(`CTRL_OFFSET, 32'h8040, 1'h0);
		@(negedge clk);
		check("coreReset", 1'h1, coreReset);
		i_mac.xfer(1'h1, `CTRL_OFFSET, 32'h4000, rd, err);
		tick(30);
		ctrlModel = 32'h0140;
		rdChk(`CTRL_OFFSET, expCtrl(), 1'h0);
		@(negedge clk);
		check("coreReset end", 1'h0, coreReset);
		$display("test soft_reset done");
		final_report();
	end
endmodule
`default_nettype wire
